// file: rtl/rmd_decode.sv
// Data-move group decode and execute for a 12-bit-instruction core
// Functional notes
// - Move-file reads addressed register and passes value unchanged to destination.
// - Destination bit 0 writes value into accumulator; file register untouched.
// - Destination bit 1 writes value back into same addressed file register.
// - Move-file sets zero flag from moved value, giving a register zero test.
// - File address is index 0 to 31; destination is single bit.
`timescale 1ns/100ps
module rmd_decode
  import rmd_pkg::*;
(
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  // Instruction from fetch
  input  wire logic                        i_instr_valid,
  input  wire logic [rmd_pkg::INSTR_W-1:0] i_instr,
  // File register read port, combinational read of o_file_raddr
  input  wire logic [rmd_pkg::DATA_W-1:0]  i_file_rdata,
  output logic      [rmd_pkg::FADDR_W-1:0] o_file_raddr,
  // File register write port
  output logic                             o_file_we,
  output logic      [rmd_pkg::FADDR_W-1:0] o_file_waddr,
  output logic      [rmd_pkg::DATA_W-1:0]  o_file_wdata,
  // Core state
  output logic      [rmd_pkg::DATA_W-1:0]  o_acc,
  output logic      [rmd_pkg::DATA_W-1:0]  o_cfg,
  output logic                             o_zero,
  output logic                             o_zero_we,
  // Decode status
  output logic                             o_unhandled
);
  import rmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic rmd_op_e decode_op(input logic [INSTR_W-1:0] ins);
    rmd_op_e op;
    op = RMD_OP_NONE;
    // Exact codes first: no-op and config load overlap no masked group
    if (ins == NOP_CODE)
    begin
      op = RMD_OP_NOP;
    end
    else if (ins == CFG_LOAD_CODE)
    begin
      op = RMD_OP_CFG_LOAD;
    end
    else if ((ins & MOVE_FILE_MASK) == MOVE_FILE_CODE)
    begin
      op = RMD_OP_MOVE_FILE;
    end
    else if ((ins & LOAD_LIT_MASK) == LOAD_LIT_CODE)
    begin
      op = RMD_OP_LOAD_LIT;
    end
    else if ((ins & STORE_ACC_MASK) == STORE_ACC_CODE)
    begin
      op = RMD_OP_STORE_ACC;
    end
    return op;
  endfunction : decode_op

  ////////////////////////////////////////////////////////////////////////////
  rmd_op_e              op;
  logic [FADDR_W-1:0]   faddr;
  logic                 dest;
  logic [DATA_W-1:0]    literal;
  logic                 file_we;
  logic [FADDR_W-1:0]   file_waddr;
  logic [DATA_W-1:0]    file_wdata;
  logic [DATA_W-1:0]    acc;
  logic [DATA_W-1:0]    cfg;
  logic                 zero;
  logic                 zero_we;
  logic                 unhandled;
  logic [DATA_W-1:0]    file_val;
  logic                 next_file_we;
  logic [FADDR_W-1:0]   next_file_waddr;
  logic [DATA_W-1:0]    next_file_wdata;
  logic [DATA_W-1:0]    next_acc;
  logic [DATA_W-1:0]    next_cfg;
  logic                 next_zero;
  logic                 next_zero_we;
  logic                 next_unhandled;

  assign faddr        = i_instr[FADDR_LSB +: FADDR_W];
  assign dest         = i_instr[DEST_BIT];
  assign literal      = i_instr[LIT_LSB +: DATA_W];
  assign op           = i_instr_valid ? decode_op(i_instr) : RMD_OP_NOP;
  // Read address is the operand field itself, so the read lands in the same cycle
  assign o_file_raddr = faddr;

  ////////////////////////////////////////////////////////////////////////////
  // Pending write bypass: the file takes a write one edge after the pulse,
  // so a move right behind a store to the same register needs this data
  always_comb
  begin
    file_val = i_file_rdata;
    if (file_we && (file_waddr == faddr))
    begin
      file_val = file_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write port group
  always_comb
  begin
    next_file_we    = 1'b0;
    next_file_waddr = file_waddr;
    next_file_wdata = file_wdata;
    case (op)
      RMD_OP_MOVE_FILE:
      begin
        if (dest)
        begin
          next_file_we    = 1'b1;
          next_file_waddr = faddr;
          next_file_wdata = file_val;
        end
      end
      RMD_OP_STORE_ACC:
      begin
        next_file_we    = 1'b1;
        next_file_waddr = faddr;
        next_file_wdata = acc;
      end
      default:
      begin
        // No other member of the group writes the file
        next_file_we = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      file_we    <= 1'b0;
      file_waddr <= '0;
      file_wdata <= '0;
    end
    else
    begin
      file_we    <= next_file_we;
      file_waddr <= next_file_waddr;
      file_wdata <= next_file_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core state group: accumulator, configuration and status pulses
  always_comb
  begin
    next_acc       = acc;
    next_cfg       = cfg;
    next_zero      = zero;
    next_zero_we   = 1'b0;
    next_unhandled = 1'b0;
    case (op)
      RMD_OP_NOP:
      begin
        next_unhandled = 1'b0;
      end
      RMD_OP_MOVE_FILE:
      begin
        if (!dest)
        begin
          next_acc = file_val;
        end
        next_zero    = (file_val == '0);
        next_zero_we = 1'b1;
      end
      RMD_OP_LOAD_LIT:
      begin
        next_acc = literal;
      end
      RMD_OP_STORE_ACC:
      begin
        // Store only drives the write port
        next_unhandled = 1'b0;
      end
      RMD_OP_CFG_LOAD:
      begin
        next_cfg = acc;
      end
      default:
      begin
        // Other groups are decoded elsewhere; flag so the core can route them
        next_unhandled = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      acc       <= ACC_RESET;
      cfg       <= CFG_RESET;
      zero      <= 1'b0;
      zero_we   <= 1'b0;
      unhandled <= 1'b0;
    end
    else
    begin
      acc       <= next_acc;
      cfg       <= next_cfg;
      zero      <= next_zero;
      zero_we   <= next_zero_we;
      unhandled <= next_unhandled;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_file_we    = file_we;
  assign o_file_waddr = file_waddr;
  assign o_file_wdata = file_wdata;
  assign o_acc        = acc;
  assign o_cfg        = cfg;
  assign o_zero       = zero;
  assign o_zero_we    = zero_we;
  assign o_unhandled  = unhandled;
endmodule : rmd_decode

// file: rtl/rmd_pkg.sv
// Constants for the data-move instruction decoder
package rmd_pkg;
  localparam int          INSTR_W       = 12;
  localparam int          DATA_W        = 8;
  localparam int          FADDR_W       = 5;
  // Opcode patterns and masks
  localparam logic [11:0] MOVE_FILE_MASK  = 12'hFC0;
  localparam logic [11:0] MOVE_FILE_CODE  = 12'h200;
  localparam logic [11:0] LOAD_LIT_MASK   = 12'hF00;
  localparam logic [11:0] LOAD_LIT_CODE   = 12'hC00;
  localparam logic [11:0] STORE_ACC_MASK  = 12'hFE0;
  localparam logic [11:0] STORE_ACC_CODE  = 12'h020;
  localparam logic [11:0] NOP_CODE        = 12'h000;
  localparam logic [11:0] CFG_LOAD_CODE   = 12'h002;
  // Field positions
  localparam int          DEST_BIT      = 5;
  localparam int          FADDR_LSB     = 0;
  localparam int          LIT_LSB       = 0;
  // Reset values
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [7:0]  CFG_RESET     = 8'hFF;
  typedef enum logic [2:0] {
    RMD_OP_NONE,
    RMD_OP_NOP,
    RMD_OP_MOVE_FILE,
    RMD_OP_LOAD_LIT,
    RMD_OP_STORE_ACC,
    RMD_OP_CFG_LOAD
  } rmd_op_e;
endpackage : rmd_pkg

// file: testbench/rmd_decode_props.sv
// Port-level assertions for the data-move decoder
`timescale 1ns/100ps
module rmd_decode_props
  import rmd_pkg::*;
(
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  // Instruction and file read
  input  wire logic                        i_instr_valid,
  input  wire logic [rmd_pkg::INSTR_W-1:0] i_instr,
  input  wire logic [rmd_pkg::DATA_W-1:0]  i_file_rdata,
  input  wire logic [rmd_pkg::FADDR_W-1:0] o_file_raddr,
  // File write port
  input  wire logic                        o_file_we,
  input  wire logic [rmd_pkg::FADDR_W-1:0] o_file_waddr,
  input  wire logic [rmd_pkg::DATA_W-1:0]  o_file_wdata,
  // Core state
  input  wire logic [rmd_pkg::DATA_W-1:0]  o_acc,
  input  wire logic [rmd_pkg::DATA_W-1:0]  o_cfg,
  input  wire logic                        o_zero,
  input  wire logic                        o_zero_we,
  input  wire logic                        o_unhandled
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire mv = i_instr_valid && (i_instr & MOVE_FILE_MASK) == MOVE_FILE_CODE;
  wire st = i_instr_valid && (i_instr & STORE_ACC_MASK) == STORE_ACC_CODE;
  wire cf = i_instr_valid && i_instr == CFG_LOAD_CODE;
  wire idle = !i_instr_valid || i_instr == NOP_CODE;
  // The file lands a write one edge after the pulse, so a pending write is the value
  wire [DATA_W-1:0] fv = (o_file_we && o_file_waddr == o_file_raddr) ? o_file_wdata
                                                                       : i_file_rdata;
  a_move_acc: assert property (mv && !i_instr[5] |=>
    o_acc == $past(fv) && !o_file_we) else $error("move to acc");
  a_move_back: assert property (mv && i_instr[5] |=> o_file_we &&
    o_file_waddr == $past(o_file_raddr) && o_file_wdata == $past(fv)) else $error("back");
  a_move_zero: assert property (mv |=>
    o_zero_we && o_zero == ($past(fv) == 8'h00)) else $error("zero flag");
  a_read_addr: assert property (o_file_raddr == i_instr[4:0])
    else $error("read address");
  a_store_acc: assert property (st |=> o_file_we && !o_zero_we &&
    o_file_wdata == $past(o_acc) && o_file_waddr == $past(i_instr[4:0])) else $error("store");
  a_cfg_load: assert property (cf |=> o_cfg == $past(o_acc))
    else $error("cfg load");
  a_idle_quiet: assert property (idle |=> $stable(o_acc) && $stable(o_cfg) &&
    !o_file_we && !o_zero_we && !o_unhandled) else $error("idle");
  cover property (mv && i_instr[5]);
  cover property (st);
  cover property (cf);
  cover property (i_instr_valid && (i_instr & LOAD_LIT_MASK) == LOAD_LIT_CODE);
  cover property (mv && o_file_we && o_file_waddr == o_file_raddr);
endmodule : rmd_decode_props
bind rmd_decode rmd_decode_props chk (.i_clk, .i_arst_n, .i_instr_valid, .i_instr,
  .i_file_rdata, .o_file_raddr, .o_file_we, .o_file_waddr, .o_file_wdata, .o_acc,
  .o_cfg, .o_zero, .o_zero_we, .o_unhandled);

// file: testbench/register_move_instruction_decode_tb_top.sv
// Self-checking bench with a reference model of the decoder
`timescale 1ns/100ps
module register_move_instruction_decode_tb_top;
  import rmd_pkg::*;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_instr_valid = 1'b0;
  logic [11:0] i_instr = 12'h000, r;
  logic [7:0] mem [32], em [32];
  logic [7:0] o_file_wdata, o_acc, o_cfg, ea = ACC_RESET, ec = CFG_RESET, ed, rd;
  logic [4:0] o_file_raddr, o_file_waddr, eaddr;
  logic o_file_we, o_zero, o_zero_we, o_unhandled, ez = 0, ezw = 0, ewe = 0, eun = 0;
  int errors = 0, checked = 0, cyc = 0, k;
  wire [7:0] i_file_rdata = mem[o_file_raddr];
  always #5 i_clk = ~i_clk;
  // Register file writes at the edge after the pulse, like the real file
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (o_file_we) mem[o_file_waddr] <= o_file_wdata;
    if (cyc == 2000)
    begin
      errors++;
      $display("wrong value at %0t ns: run did not finish in time", $time);
      test_done;
    end
  end
  rmd_decode dut (.i_clk, .i_arst_n, .i_instr_valid, .i_instr, .i_file_rdata,
    .o_file_raddr, .o_file_we, .o_file_waddr, .o_file_wdata, .o_acc, .o_cfg,
    .o_zero, .o_zero_we, .o_unhandled);
  // Checks last word's result, then models this word
  task run(input logic [11:0] w, input logic v);
    logic bad;
    @(posedge i_clk);
    i_instr <= w;
    i_instr_valid <= v;
    @(negedge i_clk);
    checked++;
    bad = {o_acc, o_cfg, o_zero, o_zero_we, o_file_we, o_unhandled} !== {ea, ec, ez, ezw, ewe, eun};
    if (ewe) bad |= {o_file_waddr, o_file_wdata} !== {eaddr, ed};
    if (bad)
    begin
      errors++;
      $display("wrong value at %0t ns: outputs differ from model", $time);
    end
    rd = em[w[4:0]];
    {ezw, ewe, eun} = 3'h0;
    if (!v || w == NOP_CODE) ;
    else if (w == CFG_LOAD_CODE) ec = ea;
    else if ((w & MOVE_FILE_MASK) == MOVE_FILE_CODE)
    begin
      {ezw, ez} = {1'b1, rd == 8'h00};
      if (w[5]) {ewe, eaddr, ed} = {1'b1, w[4:0], rd};
      else ea = rd;
    end
    else if ((w & LOAD_LIT_MASK) == LOAD_LIT_CODE) ea = w[7:0];
    else if ((w & STORE_ACC_MASK) == STORE_ACC_CODE)
    begin
      {ewe, eaddr, ed} = {1'b1, w[4:0], ea};
      em[w[4:0]] = ea;
    end
    else eun = 1'b1;
  endtask : run
  task test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial
  begin
    k = $urandom(60133);
    // Zeros in every fourth register so the zero test sees both outcomes
    foreach (mem[i])
    begin
      mem[i] = (i % 4 == 0) ? 8'h00 : 8'($urandom);
      em[i]  = mem[i];
    end
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // Store then move of one register back to back needs the write bypass
    run(12'hC5A, 1'b1);
    run(12'h023, 1'b1);
    run(12'h203, 1'b1);
    run(12'h002, 1'b1);
    run(12'hC00, 1'b1);
    run(12'h023, 1'b1);
    run(12'h223, 1'b1);
    run(12'h000, 1'b1);
    $display("directed move and bypass test done");
    repeat (600)
    begin
      k = $urandom % 6;
      r = 12'($urandom);
      run(k == 0 ? 12'h200 | r[5:0] : k == 1 ? 12'hC00 | r[7:0] : k == 2 ? 12'h020 | r[4:0] :
        k == 3 ? NOP_CODE : k == 4 ? CFG_LOAD_CODE : r, $urandom % 8 != 0);
    end
    run(NOP_CODE, 1'b0);
    $display("random stream test done");
    // Reset in mid-run: core state returns to its reset values, the file keeps its data
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    {ea, ec, ez, ezw, ewe, eun} = {ACC_RESET, CFG_RESET, 4'h0};
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    run(CFG_LOAD_CODE, 1'b1);
    run(NOP_CODE, 1'b0);
    @(negedge i_clk);
    checked++;
    foreach (em[i])
    begin
      if (mem[i] !== em[i])
      begin
        errors++;
        $display("wrong value at %0t ns: file register %0d", $time, i);
      end
    end
    $display("mid-run reset and file content test done");
    test_done;
  end
endmodule : register_move_instruction_decode_tb_top
